// *** common/sfcd_pkg.sv ***
// Function
// [R01] Every byte moves most significant bit first
// [R02] Dual output: odd bits lane1, even lane0
// [R03] Quad output: upper nibble first, lane n bit n+4
// [R04] Host sends dual address odd/even paired
// [R05] Host sends quad address nibbles, mode after
// [R06] Quad I/O read: four don't-care clocks first
// [R07] Host sends one to 256 program bytes
// [R08] Over 256 bytes wraps within same page
// [R09] Security register chosen by address bits 15..9
// [R10] Status and ID reads repeat while selected; after 15 bytes 05h sends bit 7 on every clock
// [R11] Status writes via 01h, 31h, 11h
// [R12] Status reads via 05h, 35h, 15h
// [R13] 50h volatile permit, 04h clears permit
// [R14] 06h sets write permit latch
// [R15] Host sets permit before modifying commands
// [R16] Permit command: select, eight bits, deselect
// [R17] 92h/94h identification over two/four lanes
// [R18] 4Bh, four dummy bytes, 128-bit unique number
// [R19] Modifying commands ignored without write permit
// [R20] Permit clears at reset and completion
// [R21] Volatile permit does not set latch
// [R22] Status reads accepted while busy
package sfcd_pkg;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP2 = 8'hA2;
  localparam logic [7:0] OP_PP4 = 8'h32;
  localparam logic [7:0] OP_SECPROG = 8'h42;
  localparam logic [7:0] OP_SECERASE = 8'h44;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_PE = 8'h81;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_ID2 = 8'h92;
  localparam logic [7:0] OP_ID4 = 8'h94;
  localparam logic [7:0] OP_UID = 8'h4B;
  localparam logic [7:0] SR1_RESET = 8'h00;
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [7:0] SR3_RESET = 8'h00;
  localparam int WEL_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam logic [6:0] SEC1_SEL = 7'b0001000;
  localparam logic [6:0] SEC2_SEL = 7'b0010000;
  localparam logic [6:0] SEC3_SEL = 7'b0011000;
  localparam int PAGE_BYTES = 256;
  localparam int UID_DUMMY_BITS = 32;
  localparam int QIO_DUMMY_CLKS = 4;
  localparam int BUSY_NS = 2000;
  localparam int CLK_NS = 8;
  localparam int BUSY_CYC = BUSY_NS / CLK_NS;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CMD = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_DUMMY = 6'b001000,
    ST_DATAIN = 6'b010000,
    ST_DATAOUT = 6'b100000
  } sfcd_state_t;
endpackage

// *** src/sfcd_serial_flash_command_decoder.sv ***
`timescale 1ns/100ps
module sfcd_serial_flash_command_decoder import sfcd_pkg::*; #(
  parameter int BUSY_CYCLES = BUSY_CYC,
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0123456789ABCDEF,
  parameter logic [7:0] ID_MFR = 8'h5A,
  parameter logic [7:0] ID_DEV = 8'h10
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  output logic [7:0] statusReg1,
  output logic [7:0] statusReg2,
  output logic [7:0] statusReg3,
  output logic progStrobe,
  output logic [23:0] progAddr,
  output logic [7:0] progData,
  output logic [1:0] secRegSel,
  output logic eraseStrobe,
  output logic [7:0] eraseOp,
  output logic [23:0] eraseAddr
);
  // Pin synchronisers, two back stages must agree
  logic [2:0] csS_q, csS_d, ckS_q, ckS_d;
  logic [3:0] ioS1_q, ioS2_q, ioS3_q;
  logic csLvl_q, csLvl_d, ckLvl_q, ckLvl_d;
  logic [3:0] ioLvl_q, ioLvl_d;

  sfcd_state_t st_q, st_d;
  logic [7:0] op_q, op_d;
  logic [7:0] sh_q, sh_d;
  logic [5:0] bitCnt_q, bitCnt_d;
  logic [23:0] addr_q, addr_d;
  logic [8:0] byteCnt_q, byteCnt_d;
  logic [1:0] lanes_q, lanes_d;
  logic [127:0] outSh_q, outSh_d;
  logic [7:0] sr1_q, sr1_d, sr2_q, sr2_d, sr3_q, sr3_d;
  logic [7:0] wb1_q, wb1_d, wb2_q, wb2_d;
  logic wel_q, wel_d, vwe_q, vwe_d;
  logic [15:0] busyCnt_q, busyCnt_d;
  logic [3:0] ioOut_q, ioOut_d, ioOe_q, ioOe_d;
  logic pStb_q, pStb_d, eStb_q, eStb_d;
  logic [23:0] pAddr_q, pAddr_d;
  logic [7:0] pData_q, pData_d, eOp_q, eOp_d;
  logic [23:0] eAddr_q, eAddr_d;
  logic [1:0] sec_q, sec_d;

  logic rise, fall, csEnd, csStart, busy;

  function automatic logic [1:0] laneLog(input logic [7:0] op);
    if (op == OP_PP4 || op == OP_ID4) laneLog = 2'h2;
    else if (op == OP_PP2 || op == OP_ID2) laneLog = 2'h1;
    else laneLog = 2'h0;
  endfunction

  function automatic logic needsWel(input logic [7:0] op);
    needsWel = op == OP_PP || op == OP_PP2 || op == OP_PP4 || op == OP_SECPROG ||
               op == OP_SECERASE || op == OP_SE || op == OP_BE32 || op == OP_BE64 ||
               op == OP_PE || op == OP_CE || op == OP_WRSR1 || op == OP_WRSR2 ||
               op == OP_WRSR3;
  endfunction

  always_comb begin
    csS_d = {csS_q[1:0], csN};
    ckS_d = {ckS_q[1:0], sclk};
    csLvl_d = (csS_q[1] == csS_q[2]) ? csS_q[2] : csLvl_q;
    ckLvl_d = (ckS_q[1] == ckS_q[2]) ? ckS_q[2] : ckLvl_q;
    for (int i = 0; i < 4; i++) begin
      ioLvl_d[i] = (ioS2_q[i] == ioS3_q[i]) ? ioS3_q[i] : ioLvl_q[i];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      csS_q <= 3'h7;
      ckS_q <= 3'h0;
      ioS1_q <= 4'h0;
      ioS2_q <= 4'h0;
      ioS3_q <= 4'h0;
      csLvl_q <= 1'b1;
      ckLvl_q <= 1'b0;
      ioLvl_q <= 4'h0;
    end else begin
      csS_q <= csS_d;
      ckS_q <= ckS_d;
      ioS1_q <= ioIn;
      ioS2_q <= ioS1_q;
      ioS3_q <= ioS2_q;
      csLvl_q <= csLvl_d;
      ckLvl_q <= ckLvl_d;
      ioLvl_q <= ioLvl_d;
    end
  end

  assign rise = !csLvl_q && !ckLvl_q && ckLvl_d;
  assign fall = !csLvl_q && ckLvl_q && !ckLvl_d;
  assign csEnd = !csLvl_q && csLvl_d;
  assign csStart = csLvl_q && !csLvl_d;
  assign busy = busyCnt_q != 16'h0000;

  always_comb begin
    logic [7:0] nb;
    logic [3:0] nibIn;
    logic [5:0] step;
    nb = sh_q;
    nibIn = ioLvl_d;
    step = 6'(1) << lanes_q;
    st_d = st_q;
    op_d = op_q;
    sh_d = sh_q;
    bitCnt_d = bitCnt_q;
    addr_d = addr_q;
    byteCnt_d = byteCnt_q;
    lanes_d = lanes_q;
    outSh_d = outSh_q;
    sr1_d = sr1_q;
    sr2_d = sr2_q;
    sr3_d = sr3_q;
    wb1_d = wb1_q;
    wb2_d = wb2_q;
    wel_d = wel_q;
    vwe_d = vwe_q;
    busyCnt_d = busy ? busyCnt_q - 16'h0001 : busyCnt_q;
    ioOut_d = ioOut_q;
    ioOe_d = ioOe_q;
    pStb_d = 1'b0;
    eStb_d = 1'b0;
    pAddr_d = pAddr_q;
    pData_d = pData_q;
    eOp_d = eOp_q;
    eAddr_d = eAddr_q;
    sec_d = sec_q;
    if (busy && busyCnt_q == 16'h0001) wel_d = 1'b0; // [R20]
    if (csStart) begin
      st_d = ST_CMD;
      op_d = 8'h00;
      bitCnt_d = 6'h00;
      lanes_d = 2'h0;
      byteCnt_d = 9'h000;
    end
    if (rise) begin
      // [R01] Shift in at rising edges, MSB first
      unique case (lanes_q)
        2'h2: nb = {sh_q[3:0], nibIn};
        2'h1: nb = {sh_q[5:0], nibIn[1:0]};
        default: nb = {sh_q[6:0], nibIn[0]};
      endcase
      sh_d = nb;
      bitCnt_d = bitCnt_q + step;
      unique case (st_q)
        ST_CMD: if (bitCnt_q == 6'd7) begin
          op_d = nb;
          bitCnt_d = 6'h00;
          if (busy && nb != OP_RDSR1 && nb != OP_RDSR2 && nb != OP_RDSR3) begin
            st_d = ST_IDLE; // [R22]
          end else begin
            unique case (nb)
              OP_WREN, OP_VWREN, OP_WRDI, OP_CE: st_d = ST_IDLE; // [R13] [R16]
              OP_RDSR1: begin st_d = ST_DATAOUT; outSh_d = {16{sr1_q}}; end // [R12]
              OP_RDSR2: begin st_d = ST_DATAOUT; outSh_d = {16{sr2_q}}; end // [R12]
              OP_RDSR3: begin st_d = ST_DATAOUT; outSh_d = {16{sr3_q}}; end // [R12]
              OP_UID: begin st_d = ST_DUMMY; outSh_d = UNIQUE_ID; end // [R18]
              OP_WRSR1, OP_WRSR2, OP_WRSR3: st_d = ST_DATAIN; // [R11]
              default: begin st_d = ST_ADDR; lanes_d = laneLog(nb) & {1'b1, nb[4]}; end
            endcase
          end
        end
        ST_ADDR: begin
          // [R04] [R05] Address then mode bits on 1, 2 or 4 lanes
          if (bitCnt_q < 6'd24) begin
            unique case (lanes_q)
              2'h2: addr_d = {addr_q[19:0], nibIn};
              2'h1: addr_d = {addr_q[21:0], nibIn[1:0]};
              default: addr_d = {addr_q[22:0], nibIn[0]};
            endcase
          end
          if ((op_q == OP_ID2 || op_q == OP_ID4) ? bitCnt_d == 6'd32 : bitCnt_d == 6'd24) begin
            bitCnt_d = 6'h00;
            if (op_q == OP_ID2 || op_q == OP_ID4) begin // [R17]
              outSh_d = {8{addr_q[0] ? ID_DEV : ID_MFR, addr_q[0] ? ID_MFR : ID_DEV}};
              st_d = (op_q == OP_ID4) ? ST_DUMMY : ST_DATAOUT; // [R06]
            end else if (op_q == OP_SECERASE || op_q == OP_SE || op_q == OP_BE32 ||
                         op_q == OP_BE64 || op_q == OP_PE) begin
              st_d = ST_IDLE;
            end else begin
              st_d = ST_DATAIN;
              lanes_d = laneLog(op_q) & {1'b1, op_q != OP_ID2};
            end
          end
        end
        ST_DUMMY: begin
          lanes_d = lanes_q;
          if (bitCnt_d == ((op_q == OP_UID) ? 6'(UID_DUMMY_BITS) : 6'(QIO_DUMMY_CLKS * 4))) begin
            st_d = ST_DATAOUT; // [R06] [R18]
            bitCnt_d = 6'h00;
          end
        end
        ST_DATAIN: if (bitCnt_d[2:0] == 3'h0 && bitCnt_d != bitCnt_q) begin
          bitCnt_d = 6'h00;
          byteCnt_d = byteCnt_q + 9'h001;
          if (op_q == OP_WRSR1 && byteCnt_q == 9'h000) wb1_d = nb;
          else wb2_d = nb;
          if (needsWel(op_q) && wel_q && (op_q == OP_PP || op_q == OP_PP2 ||
              op_q == OP_PP4 || op_q == OP_SECPROG)) begin // [R19]
            pStb_d = 1'b1;
            pData_d = nb;
            // [R08] Low byte wraps within the page
            pAddr_d = {addr_q[23:8], addr_q[7:0] + byteCnt_q[7:0]};
            sec_d = (addr_q[15:9] == SEC1_SEL) ? 2'h1 : (addr_q[15:9] == SEC2_SEL) ? 2'h2 :
                    (addr_q[15:9] == SEC3_SEL) ? 2'h3 : 2'h0; // [R09]
          end
        end
        default: ;
      endcase
    end
    if (fall && st_q == ST_DATAOUT) begin
      // [R02] [R03] Lane mapping, MSB first, value repeats, for 05h only 15 bytes [R10]
      ioOe_d = (lanes_q == 2'h2) ? 4'hF : (lanes_q == 2'h1) ? 4'h3 : 4'h2;
      unique case (lanes_q)
        2'h2: begin ioOut_d = outSh_q[127:124]; outSh_d = {outSh_q[123:0], outSh_q[127:124]}; end
        2'h1: begin ioOut_d = {2'h0, outSh_q[127:126]}; outSh_d = {outSh_q[125:0], outSh_q[127:126]}; end
        default: begin ioOut_d = {2'h0, outSh_q[127], 1'b0}; outSh_d = {outSh_q[126:0], outSh_q[127]}; end
      endcase
      if (op_q == OP_RDSR1) outSh_d[7:0] = sr1_q; // [R22]
    end
    if (csEnd) begin
      st_d = ST_IDLE;
      ioOe_d = 4'h0;
      ioOut_d = 4'h0;
      if (bitCnt_q == 6'h00 && !busy) begin
        unique case (op_q)
          OP_WREN: if (st_q == ST_IDLE) wel_d = 1'b1; // [R14]
          OP_WRDI: if (st_q == ST_IDLE) wel_d = 1'b0; // [R13]
          OP_VWREN: if (st_q == ST_IDLE) vwe_d = 1'b1; // [R21]
          default: ;
        endcase
        if (needsWel(op_q) && (wel_q || vwe_q)) begin // [R19]
          if (op_q == OP_WRSR1 && byteCnt_q != 9'h000 && byteCnt_q < 9'h003) begin // [R11]
            sr1_d = {wb1_q[7:2], sr1_q[1:0]};
            if (byteCnt_q == 9'h002) sr2_d = wb2_q;
            busyCnt_d = 16'(BUSY_CYCLES);
          end else if ((op_q == OP_WRSR2 || op_q == OP_WRSR3) && byteCnt_q == 9'h001) begin
            if (op_q == OP_WRSR2) sr2_d = wb2_q;
            else sr3_d = wb2_q;
            busyCnt_d = 16'(BUSY_CYCLES);
          end else if (wel_q && op_q != OP_WRSR1 && op_q != OP_WRSR2 && op_q != OP_WRSR3) begin
            busyCnt_d = 16'(BUSY_CYCLES);
            if (st_q == ST_IDLE && op_q != OP_CE) begin
              eStb_d = 1'b1;
              eOp_d = op_q;
              eAddr_d = addr_q;
            end else if (op_q == OP_CE) begin
              eStb_d = 1'b1;
              eOp_d = op_q;
            end
          end
          vwe_d = 1'b0;
        end
      end
    end
    sr1_d[WEL_BIT] = wel_d;
    sr1_d[BUSY_BIT] = busyCnt_d != 16'h0000;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      bitCnt_q <= 6'h00;
      addr_q <= 24'h000000;
      byteCnt_q <= 9'h000;
      lanes_q <= 2'h0;
      outSh_q <= 128'h0;
      sr1_q <= SR1_RESET;
      sr2_q <= SR2_RESET;
      sr3_q <= SR3_RESET;
      wb1_q <= 8'h00;
      wb2_q <= 8'h00;
      wel_q <= 1'b0; // [R20]
      vwe_q <= 1'b0;
      busyCnt_q <= 16'h0000;
      ioOut_q <= 4'h0;
      ioOe_q <= 4'h0;
      pStb_q <= 1'b0;
      eStb_q <= 1'b0;
      pAddr_q <= 24'h000000;
      pData_q <= 8'h00;
      eOp_q <= 8'h00;
      eAddr_q <= 24'h000000;
      sec_q <= 2'h0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      sh_q <= sh_d;
      bitCnt_q <= bitCnt_d;
      addr_q <= addr_d;
      byteCnt_q <= byteCnt_d;
      lanes_q <= lanes_d;
      outSh_q <= outSh_d;
      sr1_q <= sr1_d;
      sr2_q <= sr2_d;
      sr3_q <= sr3_d;
      wb1_q <= wb1_d;
      wb2_q <= wb2_d;
      wel_q <= wel_d;
      vwe_q <= vwe_d;
      busyCnt_q <= busyCnt_d;
      ioOut_q <= ioOut_d;
      ioOe_q <= ioOe_d;
      pStb_q <= pStb_d;
      eStb_q <= eStb_d;
      pAddr_q <= pAddr_d;
      pData_q <= pData_d;
      eOp_q <= eOp_d;
      eAddr_q <= eAddr_d;
      sec_q <= sec_d;
    end
  end

  assign ioOut = ioOut_q;
  assign ioOe = ioOe_q;
  assign statusReg1 = sr1_q;
  assign statusReg2 = sr2_q;
  assign statusReg3 = sr3_q;
  assign progStrobe = pStb_q;
  assign progAddr = pAddr_q;
  assign progData = pData_q;
  assign secRegSel = sec_q;
  assign eraseStrobe = eStb_q;
  assign eraseOp = eOp_q;
  assign eraseAddr = eAddr_q;
endmodule // sfcd_serial_flash_command_decoder

// *** sim/sfcd_host.sv ***
`timescale 1ns/100ps
module sfcd_host (
  output logic csN,
  output logic sclk,
  output wire logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  logic [3:0] drv = 4'h0;
  // Released lanes show the inverse of their last level, never a stale copy
  assign ioIn = (ioOe & ioOut) | (~ioOe & drv);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
  end
  task automatic sel();
    #1 csN = 1'b0;
  endtask
  task automatic desel();
    #62.5 csN = 1'b1;
    #250;
  endtask
  // One byte on w lanes, changed at the fall, sampled at the rise
  task automatic xb(input int w, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      drv = ~drv;
      if (w == 1) drv[0] = tx[7 - k];
      else if (w == 2) drv[1:0] = tx[7 - 2 * k -: 2];
      else drv = tx[7 - 4 * k -: 4];
      #62.5 sclk = 1'b1;
      if (w == 1) rx[7 - k] = ioOut[1];
      else if (w == 2) rx[7 - 2 * k -: 2] = ioOut[1:0];
      else rx[7 - 4 * k -: 4] = ioOut;
      #62.5 sclk = 1'b0;
    end
  endtask
endmodule // sfcd_host

// *** sim/sfcd_asserts.sv ***
`timescale 1ns/100ps
module sfcd_asserts import sfcd_pkg::*; #(
  parameter int BUSY_CYCLES = BUSY_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  input wire logic [7:0] statusReg1,
  input wire logic progStrobe,
  input wire logic [23:0] progAddr,
  input wire logic eraseStrobe
);
  logic [15:0] busyCnt_q, busyCnt_d;
  logic [23:0] lastAddr_q, lastAddr_d;
  logic seen_q, seen_d;
  always_comb begin
    busyCnt_d = statusReg1[BUSY_BIT] ? busyCnt_q + 16'h0001 : 16'h0000;
    lastAddr_d = progStrobe ? progAddr : lastAddr_q;
    seen_d = csN ? 1'b0 : (seen_q | progStrobe);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busyCnt_q <= 16'h0000;
      lastAddr_q <= 24'h000000;
      seen_q <= 1'b0;
    end else begin
      busyCnt_q <= busyCnt_d;
      lastAddr_q <= lastAddr_d;
      seen_q <= seen_d;
    end
  end
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Eight cycles covers the chip-select synchroniser delay
  sequence s_deselected; csN [*8]; endsequence
  sequence s_eraseStart; statusReg1[WEL_BIT] ##[0:4] statusReg1[BUSY_BIT]; endsequence
  property p_oeOff; s_deselected |-> ioOe == 4'h0; endproperty
  property p_outOnLow; $changed(ioOut) |-> !sclk; endproperty
  property p_strobeOne; progStrobe |=> !progStrobe; endproperty
  property p_wrap;
    progStrobe && seen_q |-> progAddr == {lastAddr_q[23:8], lastAddr_q[7:0] + 8'h01};
  endproperty
  property p_progWel; progStrobe |-> statusReg1[WEL_BIT]; endproperty
  property p_eraseWel; eraseStrobe |-> s_eraseStart; endproperty
  property p_welClr; $fell(statusReg1[BUSY_BIT]) |-> ##[0:2] !statusReg1[WEL_BIT]; endproperty
  property p_busyLen;
    $fell(statusReg1[BUSY_BIT]) |-> busyCnt_q >= BUSY_CYCLES - 1 && busyCnt_q <= BUSY_CYCLES + 1;
  endproperty
  property p_welRise; $rose(statusReg1[WEL_BIT]) |-> csN; endproperty
  a_oeOff: assert property (p_oeOff) else $error("lanes driven while deselected");
  a_outOnLow: assert property (p_outOnLow) else $error("lane changed with clock high");
  a_strobeOne: assert property (p_strobeOne) else $error("program strobe too long");
  a_wrap: assert property (p_wrap) else $error("byte address not wrapping in page");
  a_progWel: assert property (p_progWel) else $error("program without latch");
  a_eraseWel: assert property (p_eraseWel) else $error("erase without latch or busy");
  a_welClr: assert property (p_welClr) else $error("latch kept after completion");
  a_busyLen: assert property (p_busyLen) else $error("busy length wrong");
  a_welRise: assert property (p_welRise) else $error("latch set inside a frame");
endmodule // sfcd_asserts

// *** sim/testbench.sv ***
`timescale 1ns/100ps
module testbench import sfcd_pkg::*;;
  localparam logic [127:0] UID = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F; // Arbitrary
  localparam logic [7:0] MFR = 8'hC5; // Arbitrary
  localparam logic [7:0] DEV = 8'h3A; // Arbitrary
  localparam logic [7:0] LATCH = 8'h01 << WEL_BIT;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic csN, sclk, progStrobe, eraseStrobe;
  wire logic [3:0] ioIn;
  logic [3:0] ioOut, ioOe;
  logic [7:0] statusReg1, statusReg2, statusReg3, progData, eraseOp, rd;
  logic [23:0] progAddr, eraseAddr;
  logic [1:0] secRegSel;
  logic [33:0] capQ[$];
  logic [31:0] ersQ[$];
  logic [7:0] rdOps [3] = '{OP_RDSR1, OP_RDSR2, OP_RDSR3};
  logic [7:0] rdExp [3] = '{LATCH, SR2_RESET, SR3_RESET};
  logic [7:0] wrOps [3] = '{OP_WRSR1, OP_WRSR2, OP_WRSR3};
  int errors = 0;
  int num_checks = 0;
  always #4 clock = ~clock;
  sfcd_serial_flash_command_decoder #(.BUSY_CYCLES(400), .UNIQUE_ID(UID), .ID_MFR(MFR),
    .ID_DEV(DEV)) u_dut (.clock(clock), .nrst(nrst), .csN(csN), .sclk(sclk), .ioIn(ioIn),
    .ioOut(ioOut), .ioOe(ioOe), .statusReg1(statusReg1), .statusReg2(statusReg2),
    .statusReg3(statusReg3), .progStrobe(progStrobe), .progAddr(progAddr),
    .progData(progData), .secRegSel(secRegSel), .eraseStrobe(eraseStrobe),
    .eraseOp(eraseOp), .eraseAddr(eraseAddr));
  sfcd_host u_host (.csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  always @(posedge clock) begin
    if (progStrobe === 1'b1) capQ.push_back({secRegSel, progAddr, progData});
    if (eraseStrobe === 1'b1) ersQ.push_back({eraseOp, eraseAddr});
  end
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic endTest(input string name);
    $display("test %s done", name);
  endtask
  task automatic txn(input logic [7:0] op, input int na, input logic [23:0] a, input int nd,
      input logic [15:0] d);
    u_host.sel();
    u_host.xb(1, op, rd);
    for (int i = 0; i < na; i++) u_host.xb(1, a[23 - 8 * i -: 8], rd);
    for (int i = 0; i < nd; i++) u_host.xb(1, d[15 - 8 * i -: 8], rd);
    u_host.desel();
  endtask
  task automatic cmd(input logic [7:0] op);
    txn(op, 0, 24'h0, 0, 16'h0);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 1000 && statusReg1[BUSY_BIT] !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    chk("idle", statusReg1[BUSY_BIT], 1'b0);
  endtask
  initial begin
    #200000;
    errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    chk("sr1", statusReg1, SR1_RESET);
    chk("sr2", statusReg2, SR2_RESET);
    chk("sr3", statusReg3, SR3_RESET);
    cmd(OP_WREN);
    chk("latch set", statusReg1[WEL_BIT], 1'b1);
    for (int i = 0; i < 3; i++) begin
      u_host.sel();
      u_host.xb(1, rdOps[i], rd);
      repeat (2) begin
        u_host.xb(1, 8'h00, rd);
        chk("status read", rd, rdExp[i]);
      end
      u_host.desel();
    end
    cmd(OP_WRDI);
    chk("latch clear", statusReg1[WEL_BIT], 1'b0);
    txn(OP_WRSR2, 0, 24'h0, 1, 16'hFF00);
    txn(OP_PP, 3, 24'h000010, 1, 16'h5500);
    chk("sr2 kept", statusReg2, SR2_RESET);
    chk("no busy", statusReg1[BUSY_BIT], 1'b0);
    chk("no program", capQ.size(), 0);
    cmd(OP_VWREN);
    chk("latch after volatile", statusReg1[WEL_BIT], 1'b0);
    endTest("permit");
    cmd(OP_WREN);
    txn(OP_PP, 3, 24'h0001FF, 2, 16'h3CC3);
    u_host.sel();
    u_host.xb(1, OP_RDSR1, rd);
    u_host.xb(1, 8'h00, rd);
    u_host.desel();
    chk("poll busy", rd, LATCH | (8'h01 << BUSY_BIT));
    waitIdle();
    chk("latch after program", statusReg1, 8'h00);
    chk("byte count", capQ.size(), 2);
    chk("first byte", capQ.pop_front(), {2'd0, 24'h0001FF, 8'h3C});
    chk("wrapped byte", capQ.pop_front(), {2'd0, 24'h000100, 8'hC3});
    cmd(OP_WREN);
    txn(OP_SECPROG, 3, {8'h00, SEC2_SEL, 9'h005}, 1, 16'h5A00);
    waitIdle();
    chk("security", capQ.pop_front(), {2'd2, 8'h00, SEC2_SEL, 9'h005, 8'h5A});
    cmd(OP_WREN);
    txn(OP_SE, 3, 24'h001000, 0, 16'h0);
    waitIdle();
    chk("erase", ersQ.pop_front(), {OP_SE, 24'h001000});
    for (int i = 0; i < 3; i++) begin
      cmd(OP_WREN);
      txn(wrOps[i], 0, 24'h0, 1, 16'hA500);
      chk("status write busy", statusReg1[BUSY_BIT], 1'b1);
      waitIdle();
      chk("status written", i == 0 ? statusReg1 : i == 1 ? statusReg2 : statusReg3,
        i == 0 ? 8'hA4 : 8'hA5);
    end
    endTest("modify");
    u_host.sel();
    u_host.xb(1, OP_UID, rd);
    repeat (4) u_host.xb(1, 8'h00, rd);
    for (int i = 0; i < 2; i++) begin
      u_host.xb(1, 8'h00, rd);
      chk("unique id", rd, UID[127 - 8 * i -: 8]);
    end
    u_host.desel();
    for (int w = 2; w <= 4; w += 2) begin
      u_host.sel();
      u_host.xb(1, w == 2 ? OP_ID2 : OP_ID4, rd);
      repeat (4) u_host.xb(w, 8'h00, rd);
      if (w == 4) repeat (2) u_host.xb(4, 8'h00, rd);
      for (int i = 0; i < 3; i++) begin
        u_host.xb(w, 8'h00, rd);
        chk("ident", rd, i == 1 ? DEV : MFR);
      end
      u_host.desel();
    end
    endTest("ident");
    summarize();
  end
endmodule // testbench
bind sfcd_serial_flash_command_decoder sfcd_asserts #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
  .clock(clock), .nrst(nrst), .csN(csN), .sclk(sclk), .ioOut(ioOut), .ioOe(ioOe),
  .statusReg1(statusReg1), .progStrobe(progStrobe), .progAddr(progAddr),
  .eraseStrobe(eraseStrobe));
